/* rtl/mpsc_pkg.sv */
// constants, field layouts and types for the multifunction pin and shutdown control block
//
// Overview of operation
// - standalone mode: faults block FETs, fuse blows, FETs recover without host action
// - manual mode: faults only raise flags; host must turn the FETs off itself
// - host serial link selects I2C (default) or single-wire host link
// - each active-high pin output selects external or core regulator as its high level
// - alarm and both switch-off pins can be general-purpose outputs set by command
// - those three pins can keep a weak pulldown or weak pullup on continuously
// - charge-off pin blocks charge FET; discharge-off pin blocks discharge or all FETs
// - alarm, switch-off and both temperature pins can be thermistor inputs
// - auxiliary analog pin can be a general-purpose ADC channel
// - reset/shutdown pin high resets the mode and link bits and the pin configuration, serial interface included
// - that reset leaves the FET drive and fuse drive state unchanged
// - pin high for 1 second enters shutdown: FETs, oscillators, all regulators off
// - external regulator voltage accepts exactly five codes: 1.8, 2.5, 3.0, 3.3, 5.0 V
// - by default external regulator and preregulator on, external set to 3.3 V
// - at power-up the stored settings load themselves and set the external regulator
// - combined discharge-off function turns off charge, precharge, discharge, predischarge
// - a released switch-off pin re-enables its FET only when nothing else blocks it
package mpsc_pkg;
	// clock and shutdown hold time
	localparam int unsigned CLK_KHZ = 125000;
	localparam int unsigned SHUT_HOLD_MS = 1000;
	localparam int unsigned SHUT_HOLD_CYC = SHUT_HOLD_MS * CLK_KHZ;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PINCFG = 8'h04;
	localparam logic [7:0] OFS_REGCFG = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_MASK = 8'h10;
	localparam logic [7:0] OFS_STATE = 8'h14;
	// control register bits
	localparam int CTRL_AUTO = 0;
	localparam int CTRL_LINK = 1;
	localparam int CTRL_HCHG = 2;
	localparam int CTRL_HDSG = 3;
	localparam logic [3:0] CTRL_RST = 4'h1;
	// pin configuration fields, pin 0 alarm, 1 charge-off, 2 discharge-off
	localparam int PIN_FN_W = 3;
	localparam int PIN_SUP = 9;
	localparam int PIN_PEN = 12;
	localparam int PIN_PUP = 15;
	localparam int PIN_LVL = 18;
	localparam int PIN_TS1 = 21;
	localparam int PIN_TS2 = 22;
	localparam int PIN_AUX = 23;
	localparam logic [23:0] PINCFG_RST = 24'h000000;
	// regulator configuration bits
	localparam int REG_EXT_EN = 0;
	localparam int REG_PRE_EN = 1;
	localparam int REG_CODE = 2;
	localparam logic [2:0] VCODE_MAX = 3'h4;
	localparam logic [4:0] REGCFG_RST = 5'h0f;
	// status and mask bits
	localparam int ST_FAULT = 0;
	localparam int ST_CHGPIN = 1;
	localparam int ST_DSGPIN = 2;
	localparam int ST_RSTPIN = 3;
	localparam int NUM_EV = 4;
	// pin function codes
	typedef enum logic [2:0] {
		FN_NONE = 3'b000,
		FN_ALARM = 3'b001,
		FN_LINK = 3'b010,
		FN_SWOFF = 3'b011,
		FN_BOTH = 3'b100,
		FN_GPO = 3'b101,
		FN_THERM = 3'b110
	} mpsc_func_e;
	// shutdown sequence states
	typedef enum logic [1:0] {
		SD_RUN = 2'b00,
		SD_HOLD = 2'b01,
		SD_SHUT = 2'b10
	} mpsc_sd_e;
endpackage

/* rtl/mpsc_top.sv */
// multifunction pin, regulator and reset/shutdown control with an AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module mpsc_top #(
	parameter int unsigned HOLD_CYCLES = mpsc_pkg::SHUT_HOLD_CYC // shutdown hold
) (
	input wire logic ref_clk, // 125 MHz clock
	input wire logic arst_n, // async reset
	input wire logic hsel, // slave select
	input wire logic [7:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write
	input wire logic [2:0] hsize, // size, word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	input wire logic rstShutPin, // reset/shutdown pin level
	input wire logic chgFault, // charge protection fault
	input wire logic dsgFault, // discharge protection fault
	input wire logic fuseReq, // permanent fail asks for fuse
	input wire logic chgReq, // sequencer wants charge switch
	input wire logic dsgReq, // sequencer wants discharge switch
	input wire logic preChgReq, // sequencer wants precharge switch
	input wire logic preDsgReq, // sequencer wants predischarge switch
	input wire logic linkTxLow, // single-wire link pulls low
	input wire logic [4:0] otpRegCfg, // stored regulator setting
	input wire logic [2:0] mfIn, // multifunction pin inputs
	output logic [2:0] mfOut, // multifunction pin outputs
	output logic [2:0] mfOe, // multifunction pin enables
	output logic [2:0] mfSupplyExt, // high level from external regulator
	output logic [2:0] mfPullUp, // weak pullup on
	output logic [2:0] mfPullDn, // weak pulldown on
	output logic [4:0] thermEn, // thermistor bias per pin
	output logic auxAdcEn, // aux analog channel selected
	output logic linkSel, // 1 single-wire link, 0 I2C
	output logic linkRx, // single-wire link receive
	output logic serialRst, // serial interface reset
	output logic chgDrive, // charge switch drive
	output logic dsgDrive, // discharge switch drive
	output logic preChgDrive, // precharge switch drive
	output logic preDsgDrive, // predischarge switch drive
	output logic fuseDrive, // fuse drive
	output logic extRegEn, // external regulator enable
	output logic [2:0] extRegCode, // external regulator voltage
	output logic preRegEn, // preregulator enable
	output logic coreRegEn, // core regulator enable
	output logic oscEn, // internal oscillators enable
	output logic shutdownMode, // device in shutdown
	output logic irq // interrupt level
);
	import mpsc_pkg::*;

	// reset release through two flops
	logic rstMeta;
	logic rstN;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN <= rstMeta;
		end
	end

	// register state
	logic [3:0] ctrl;
	logic [23:0] pinCfg;
	logic [4:0] regCfg;
	logic [NUM_EV-1:0] status;
	logic [NUM_EV-1:0] mask;
	logic otpLoaded;
	logic softRst;
	mpsc_sd_e sdState;
	logic [31:0] holdCnt;
	logic [2:0] pinPrev;
	logic faultPrev;
	logic rstPinPrev;

	// ahb address phase decode
	logic wrPend;
	logic [7:0] wrAddr;
	wire takeXfer = hsel & htrans[1] & hready;
	wire takeRd = takeXfer & ~hwrite;
	wire takeWr = takeXfer & hwrite;
	wire wrCtrl = wrPend & (wrAddr == OFS_CTRL);
	wire wrPin = wrPend & (wrAddr == OFS_PINCFG);
	wire wrReg = wrPend & (wrAddr == OFS_REGCFG);
	wire wrStat = wrPend & (wrAddr == OFS_STATUS);
	wire wrMask = wrPend & (wrAddr == OFS_MASK);

	// pin function fields
	wire mpsc_func_e fnAlarm = mpsc_func_e'(pinCfg[2:0]);
	wire mpsc_func_e fnChg = mpsc_func_e'(pinCfg[5:3]);
	wire mpsc_func_e fnDsg = mpsc_func_e'(pinCfg[8:6]);
	wire isShut = (sdState == SD_SHUT);
	wire autoMode = ctrl[CTRL_AUTO];

	// switch-off pin decode
	wire chgPinOff = (fnChg == FN_SWOFF) & mfIn[1];
	wire dsgPinOff = (fnDsg == FN_SWOFF) & mfIn[2];
	wire bothPinOff = (fnDsg == FN_BOTH) & mfIn[2];

	// blocking causes per switch group
	wire chgBlock = ctrl[CTRL_HCHG] | chgPinOff | bothPinOff |
		(autoMode & chgFault) | isShut;
	wire dsgBlock = ctrl[CTRL_HDSG] | dsgPinOff | bothPinOff |
		(autoMode & dsgFault) | isShut;
	wire next_chg = chgReq & ~chgBlock;
	wire next_dsg = dsgReq & ~dsgBlock;
	wire next_preChg = preChgReq & ~chgBlock;
	wire next_preDsg = preDsgReq & ~dsgBlock;
	wire next_fuse = fuseDrive | (autoMode & fuseReq);

	// regulator code check and written value
	wire [2:0] wrCode = hwdata[REG_CODE +: 3];
	wire codeOk = (wrCode <= VCODE_MAX);
	wire [2:0] otpCode = otpRegCfg[REG_CODE +: 3];
	wire [2:0] next_code = !otpLoaded ? ((otpCode <= VCODE_MAX) ? otpCode : regCfg[4:2]) :
		((wrReg && codeOk) ? wrCode : regCfg[4:2]);

	// events for the sticky status
	wire [NUM_EV-1:0] evSet = {rstShutPin & ~rstPinPrev,
		(fnDsg == FN_SWOFF || fnDsg == FN_BOTH) & mfIn[2] & ~pinPrev[2],
		(fnChg == FN_SWOFF) & mfIn[1] & ~pinPrev[1],
		(chgFault | dsgFault) & ~faultPrev};
	wire [NUM_EV-1:0] evClr = wrStat ? hwdata[NUM_EV-1:0] : '0;
	wire [NUM_EV-1:0] next_status = (status & ~evClr) | evSet;
	wire next_irq = |(next_status & mask);

	// read mux
	logic [31:0] rdMux;
	assign rdMux = (haddr == OFS_CTRL) ? {28'h0000000, ctrl} :
		(haddr == OFS_PINCFG) ? {8'h00, pinCfg} :
		(haddr == OFS_REGCFG) ? {27'h0000000, regCfg} :
		(haddr == OFS_STATUS) ? {28'h0000000, status} :
		(haddr == OFS_MASK) ? {28'h0000000, mask} :
		(haddr == OFS_STATE) ? {24'h000000, sdState, fuseDrive, preDsgDrive,
			preChgDrive, dsgDrive, chgDrive, softRst} : 32'h00000000;

	// ahb slave, zero wait, always okay
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wrPend <= 1'b0;
			wrAddr <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wrPend <= takeWr;
			wrAddr <= takeWr ? haddr : wrAddr;
			hrdata <= takeRd ? rdMux : hrdata;
		end
	end

	// mode and link control bits and pin configuration, back to reset values while reset pin is high
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			ctrl <= CTRL_RST;
			pinCfg <= PINCFG_RST;
		end else if (softRst) begin
			ctrl <= {ctrl[CTRL_HDSG:CTRL_HCHG], CTRL_RST[1:0]};
			pinCfg <= PINCFG_RST;
		end else begin
			ctrl <= wrCtrl ? hwdata[3:0] : ctrl;
			pinCfg <= wrPin ? hwdata[23:0] : pinCfg;
		end
	end

	// regulator configuration with power-up load of stored setting
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			regCfg <= REGCFG_RST;
			otpLoaded <= 1'b0;
		end else begin
			otpLoaded <= 1'b1;
			regCfg[REG_EXT_EN] <= !otpLoaded ? otpRegCfg[REG_EXT_EN] :
				(wrReg ? hwdata[REG_EXT_EN] : regCfg[REG_EXT_EN]);
			regCfg[REG_PRE_EN] <= !otpLoaded ? otpRegCfg[REG_PRE_EN] :
				(wrReg ? hwdata[REG_PRE_EN] : regCfg[REG_PRE_EN]);
			regCfg[4:2] <= next_code;
		end
	end

	// sticky status, mask and interrupt; set wins over clear
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			status <= '0;
			mask <= '0;
			irq <= 1'b0;
			pinPrev <= 3'h0;
			faultPrev <= 1'b0;
			rstPinPrev <= 1'b0;
		end else begin
			status <= next_status;
			mask <= wrMask ? hwdata[NUM_EV-1:0] : mask;
			irq <= next_irq;
			pinPrev <= mfIn;
			faultPrev <= chgFault | dsgFault;
			rstPinPrev <= rstShutPin;
		end
	end

	// reset/shutdown pin hold timer
	wire holdDone = (holdCnt >= HOLD_CYCLES - 32'd1);
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			sdState <= SD_RUN;
			holdCnt <= 32'h00000000;
			softRst <= 1'b0;
		end else begin
			softRst <= rstShutPin & ~isShut;
			case (sdState)
				SD_RUN: begin
					holdCnt <= 32'h00000000;
					sdState <= rstShutPin ? SD_HOLD : SD_RUN;
				end
				SD_HOLD: begin
					holdCnt <= rstShutPin ? holdCnt + 32'd1 : 32'h00000000;
					sdState <= !rstShutPin ? SD_RUN : (holdDone ? SD_SHUT : SD_HOLD);
				end
				SD_SHUT: begin
					sdState <= SD_SHUT;
				end
				default: begin
					sdState <= SD_RUN;
				end
			endcase
		end
	end

	// switch and fuse drives, frozen while the reset pin holds logic in reset
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			chgDrive <= 1'b0;
			dsgDrive <= 1'b0;
			preChgDrive <= 1'b0;
			preDsgDrive <= 1'b0;
			fuseDrive <= 1'b0;
		end else if (isShut) begin
			chgDrive <= 1'b0;
			dsgDrive <= 1'b0;
			preChgDrive <= 1'b0;
			preDsgDrive <= 1'b0;
		end else if (!softRst && !rstShutPin) begin
			chgDrive <= next_chg;
			dsgDrive <= next_dsg;
			preChgDrive <= next_preChg;
			preDsgDrive <= next_preDsg;
			fuseDrive <= next_fuse;
		end
	end

	// power outputs, link select and serial reset
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			extRegEn <= 1'b1;
			extRegCode <= REGCFG_RST[4:2];
			preRegEn <= 1'b1;
			coreRegEn <= 1'b1;
			oscEn <= 1'b1;
			shutdownMode <= 1'b0;
			linkSel <= 1'b0;
			linkRx <= 1'b1;
			serialRst <= 1'b1;
		end else begin
			extRegEn <= regCfg[REG_EXT_EN] & ~isShut;
			extRegCode <= regCfg[4:2];
			preRegEn <= regCfg[REG_PRE_EN] & ~isShut;
			coreRegEn <= ~isShut;
			oscEn <= ~isShut;
			shutdownMode <= isShut;
			linkSel <= ctrl[CTRL_LINK];
			linkRx <= mfIn[0] | (fnAlarm != FN_LINK);
			serialRst <= rstShutPin | softRst;
		end
	end

	// per-pin next values for alarm, charge-off and discharge-off pins
	wire [2:0] next_pinOe;
	wire [2:0] next_pinOut;
	wire [2:0] pinTherm;
	for (genvar i = 0; i < 3; i++) begin : g_pin
		wire mpsc_func_e fn = mpsc_func_e'(pinCfg[i*PIN_FN_W +: PIN_FN_W]);
		wire isAlarm = (i == 0) && (fn == FN_ALARM);
		wire isLink = (i == 0) && (fn == FN_LINK);
		wire isGpo = (fn == FN_GPO);
		assign next_pinOe[i] = isGpo | isAlarm | (isLink & linkTxLow);
		assign next_pinOut[i] = isGpo ? pinCfg[PIN_LVL+i] : (isAlarm & next_irq);
		assign pinTherm[i] = (fn == FN_THERM);
	end

	// pin output stage, one process so each output has a single driver
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			mfOe <= 3'h0;
			mfOut <= 3'h0;
			mfSupplyExt <= 3'h0;
			mfPullUp <= 3'h0;
			mfPullDn <= 3'h0;
			thermEn <= 5'h00;
			auxAdcEn <= 1'b0;
		end else begin
			mfOe <= next_pinOe;
			mfOut <= next_pinOut;
			mfSupplyExt <= pinCfg[PIN_SUP +: 3];
			mfPullUp <= pinCfg[PIN_PEN +: 3] & pinCfg[PIN_PUP +: 3];
			mfPullDn <= pinCfg[PIN_PEN +: 3] & ~pinCfg[PIN_PUP +: 3];
			thermEn <= {pinCfg[PIN_TS2], pinCfg[PIN_TS1], pinTherm};
			auxAdcEn <= pinCfg[PIN_AUX];
		end
	end

	// checks
	property p_chgPinBlocks;
		@(posedge ref_clk) disable iff (!rstN)
		(chgPinOff && !softRst && !rstShutPin && !isShut) |=> !chgDrive && !preChgDrive;
	endproperty
	a_chgPinBlocks: assert property (p_chgPinBlocks) else $error("charge-off pin ignored");

	property p_all_switches_off_function;
		@(posedge ref_clk) disable iff (!rstN)
		(bothPinOff && !softRst && !rstShutPin) |=> !(chgDrive | dsgDrive | preChgDrive | preDsgDrive);
	endproperty
	a_all_switches_off_function: assert property (p_all_switches_off_function) else $error("combined off left a switch on");

	property p_manualNoBlock;
		@(posedge ref_clk) disable iff (!rstN)
		(!autoMode && chgReq && chgFault && !ctrl[CTRL_HCHG] && !chgPinOff && !bothPinOff
			&& !softRst && !rstShutPin && !isShut) |=> chgDrive;
	endproperty
	a_manualNoBlock: assert property (p_manualNoBlock) else $error("manual mode blocked on fault");

	property p_autoBlock;
		@(posedge ref_clk) disable iff (!rstN)
		(autoMode && dsgFault && !softRst && !rstShutPin) |=> !dsgDrive;
	endproperty
	a_autoBlock: assert property (p_autoBlock) else $error("standalone fault did not block");

	property p_freeze;
		@(posedge ref_clk) disable iff (!rstN)
		(softRst && !isShut) ##1 !isShut |-> $stable(chgDrive) && $stable(fuseDrive);
	endproperty
	a_freeze: assert property (p_freeze) else $error("drive changed during pin reset");

	property p_serialRst;
		@(posedge ref_clk) disable iff (!rstN)
		rstShutPin |=> serialRst;
	endproperty
	a_serialRst: assert property (p_serialRst) else $error("serial reset missing");

	property p_holdClear;
		@(posedge ref_clk) disable iff (!rstN)
		(sdState == SD_HOLD && !rstShutPin) |=> sdState == SD_RUN && holdCnt == 32'h00000000;
	endproperty
	a_holdClear: assert property (p_holdClear) else $error("hold timer not cleared");

	property p_shutOff;
		@(posedge ref_clk) disable iff (!rstN)
		isShut |=> !extRegEn && !preRegEn && !coreRegEn && !oscEn && !chgDrive && !dsgDrive;
	endproperty
	a_shutOff: assert property (p_shutOff) else $error("shutdown left power on");

	property p_codeLegal;
		@(posedge ref_clk) disable iff (!rstN)
		1'b1 |-> regCfg[4:2] <= VCODE_MAX;
	endproperty
	a_codeLegal: assert property (p_codeLegal) else $error("illegal regulator code");

	property p_linkSel;
		@(posedge ref_clk) disable iff (!rstN)
		softRst |-> ##2 !linkSel;
	endproperty
	a_linkSel: assert property (p_linkSel) else $error("link not back to I2C after reset");

	property p_gpoLevel;
		@(posedge ref_clk) disable iff (!rstN)
		(fnChg == FN_GPO) |=> mfOe[1] && (mfOut[1] == $past(pinCfg[PIN_LVL+1]));
	endproperty
	a_gpoLevel: assert property (p_gpoLevel) else $error("gpo level not driven");
endmodule
`default_nettype wire

/* verif/mpsc_host_model.sv */
// host-side model of the pins: reset/shutdown line, alarm line and the two switch-off lines
`timescale 1ns/10ps
`default_nettype none
module mpsc_host_model (
	input wire logic ref_clk, // device clock
	input wire logic shutReq, // bench wants reset or shutdown
	input wire logic [1:0] offReq, // bench asserts charge-off, discharge-off
	input wire logic [2:0] mfOut, // device pin level
	input wire logic [2:0] mfOe, // device pin enable
	input wire logic [2:0] mfPullUp, // device weak pullup
	input wire logic [2:0] mfPullDn, // device weak pulldown
	output logic rstShutPin, // reset/shutdown pin
	output logic [2:0] mfIn // resolved pin levels
);
	logic lastAlarm = 1'b0;
	// pin stays low unless a reset or shutdown is wanted
	assign rstShutPin = shutReq;
	// floating alarm pin must not hold its last value
	always @(posedge ref_clk) begin
		lastAlarm <= mfIn[0];
	end
	// alarm pin: device drive, then weak pull, else toggling
	assign mfIn[0] = mfOe[0] ? mfOut[0] : mfPullUp[0] ? 1'b1 : mfPullDn[0] ? 1'b0 : ~lastAlarm;
	// off pins: host drives whenever the device does not
	assign mfIn[2:1] = (mfOe[2:1] & mfOut[2:1]) | (~mfOe[2:1] & offReq);
endmodule
`default_nettype wire

/* verif/mpsc_tb_top.sv */
// self-checking bench for the pin, regulator and shutdown control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin nChecks++; if ((gt) !== (ex)) begin errors++; \
	$display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module mpsc_tb_top;
	import mpsc_pkg::*;
	localparam int HOLD = 20;
	logic ref_clk = 1'b0;
	logic arst_n, hsel, hwrite, hready, shutReq, chgFault, dsgFault, fuseReq, linkTxLow;
	logic chgReq, dsgReq, preChgReq, preDsgReq, rstShutPin;
	logic [7:0] haddr;
	logic [1:0] htrans, offReq;
	logic [2:0] hsize, mfIn;
	logic [4:0] otpRegCfg;
	logic [31:0] hwdata, hrdata, rd, pc, r;
	logic hreadyout, hresp, auxAdcEn, linkSel, linkRx, serialRst, irq, shutdownMode;
	logic chgDrive, dsgDrive, preChgDrive, preDsgDrive, fuseDrive;
	logic extRegEn, preRegEn, coreRegEn, oscEn;
	logic [2:0] mfOut, mfOe, mfSupplyExt, mfPullUp, mfPullDn, extRegCode;
	logic [4:0] thermEn;
	wire [20:0] pinSeen = {auxAdcEn, thermEn, mfPullDn, mfPullUp, mfSupplyExt, mfOe,
		mfOut & mfOe};
	wire [8:0] pwrSeen = {shutdownMode, chgDrive, dsgDrive, preChgDrive, preDsgDrive, oscEn,
		coreRegEn, preRegEn, extRegEn};
	int errors = 0;
	int nChecks = 0;
	int seed = 23043;
	assign hready = hreadyout;
	always #4 ref_clk = ~ref_clk;
	mpsc_top #(.HOLD_CYCLES(HOLD)) mpsc_top_inst (.ref_clk, .arst_n, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rstShutPin, .chgFault,
		.dsgFault, .fuseReq, .chgReq, .dsgReq, .preChgReq, .preDsgReq, .linkTxLow, .otpRegCfg,
		.mfIn, .mfOut, .mfOe, .mfSupplyExt, .mfPullUp, .mfPullDn, .thermEn, .auxAdcEn, .linkSel,
		.linkRx, .serialRst, .chgDrive, .dsgDrive, .preChgDrive, .preDsgDrive, .fuseDrive,
		.extRegEn, .extRegCode, .preRegEn, .coreRegEn, .oscEn, .shutdownMode, .irq);
	mpsc_host_model mpsc_host_model_inst (.ref_clk, .shutReq, .offReq, .mfOut, .mfOe,
		.mfPullUp, .mfPullDn, .rstShutPin, .mfIn);
	// wait whole cycles, then step off the edge
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// one single AHB-Lite transfer; read data lands in rd
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// expected pin outputs for a pin configuration word
	function automatic logic [20:0] pinExp(input logic [23:0] c);
		logic [2:0] oe, out, th;
		for (int i = 0; i < 3; i++) begin
			oe[i] = c[3*i+:3] == FN_GPO;
			th[i] = c[3*i+:3] == FN_THERM;
			out[i] = oe[i] & c[PIN_LVL+i];
		end
		return {c[PIN_AUX], c[PIN_TS2], c[PIN_TS1], th, c[PIN_PEN+:3] & ~c[PIN_PUP+:3],
			c[PIN_PEN+:3] & c[PIN_PUP+:3], c[PIN_SUP+:3], oe, out};
	endfunction
	// verdict and end of run
	task automatic finish_test;
		if (errors == 0 && nChecks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// cut a hang short
	initial begin
		#40000;
		errors++;
		finish_test;
	end
	// main sequence
	initial begin
		{arst_n, hsel, haddr, htrans, hwrite, hwdata, shutReq, chgFault, dsgFault} = '0;
		{fuseReq, chgReq, dsgReq, preChgReq, preDsgReq, linkTxLow, offReq} = '0;
		hsize = 3'h2;
		otpRegCfg = 5'h13;
		wt(4);
		`CHK("reg default", 5'h0f, {extRegCode, preRegEn, extRegEn})
		`CHK("link default", 1'b0, linkSel)
		arst_n = 1'b1;
		wt(4);
		bus(OFS_REGCFG, 1'b0, 32'h0);
		`CHK("stored reg", 32'h13, rd)
		`CHK("stored code", 3'h4, extRegCode)
		for (int c = 0; c < 8; c++) begin
			bus(OFS_REGCFG, 1'b1, {27'h0, 3'(c), 2'b11});
			wt(2);
			`CHK("reg code", (c > 4) ? 3'h4 : 3'(c), extRegCode)
		end
		bus(OFS_CTRL, 1'b1, 32'h3);
		wt(2);
		`CHK("link sel", 1'b1, linkSel)
		bus(8'h40, 1'b0, 32'h0);
		`CHK("unmapped", 33'h0, {hresp, rd})
		bus(OFS_CTRL, 1'b1, 32'h1);
		repeat (4) begin
			pc = $random(seed);
			r = $random(seed);
			for (int i = 0; i < 3; i++) begin
				pc[3*i+:3] = r[i] ? FN_GPO : FN_THERM;
			end
			pc[31:24] = 8'h00;
			bus(OFS_PINCFG, 1'b1, pc);
			wt(2);
			`CHK("pins", pinExp(pc[23:0]), pinSeen)
		end
		// single-wire link on the alarm pin, pulled up when released
		bus(OFS_PINCFG, 1'b1, 32'h9002);
		linkTxLow <= 1'b1;
		wt(3);
		`CHK("link low", 3'b100, {mfOe[0], mfOut[0], linkRx})
		linkTxLow <= 1'b0;
		wt(3);
		`CHK("link released", 2'b01, {mfOe[0], linkRx})
		// alarm on pin 0, charge-off on pin 1, combined off on pin 2
		{chgReq, dsgReq, preChgReq, preDsgReq} <= 4'hf;
		bus(OFS_PINCFG, 1'b1, 32'h119);
		wt(3);
		`CHK("drives on", 4'hf, {chgDrive, dsgDrive, preChgDrive, preDsgDrive})
		offReq <= 2'b01;
		wt(3);
		`CHK("chg off pin", 2'b01, {chgDrive, dsgDrive})
		bus(OFS_CTRL, 1'b1, 32'h5);
		offReq <= 2'b00;
		wt(3);
		`CHK("host still off", 1'b0, chgDrive)
		bus(OFS_CTRL, 1'b1, 32'h1);
		wt(3);
		`CHK("chg back", 1'b1, chgDrive)
		offReq <= 2'b10;
		wt(3);
		`CHK("all off pin", 4'h0, {chgDrive, dsgDrive, preChgDrive, preDsgDrive})
		offReq <= 2'b00;
		wt(3);
		`CHK("all back", 4'hf, {chgDrive, dsgDrive, preChgDrive, preDsgDrive})
		// fault in standalone, then interrupt mask and clear
		bus(OFS_MASK, 1'b1, 32'h1);
		{chgFault, dsgFault} <= 2'b11;
		wt(3);
		`CHK("fault block", 5'b00111, {chgDrive, dsgDrive, irq, mfOe[0], mfOut[0]})
		{chgFault, dsgFault} <= 2'b00;
		wt(3);
		`CHK("recover", 2'b11, {chgDrive, dsgDrive})
		bus(OFS_STATUS, 1'b0, 32'h0);
		`CHK("status", 1'b1, rd[ST_FAULT])
		bus(OFS_MASK, 1'b1, 32'h0);
		wt(2);
		`CHK("masked irq", 2'b00, {irq, mfOut[0]})
		bus(OFS_MASK, 1'b1, 32'h1);
		bus(OFS_STATUS, 1'b1, 32'h1);
		wt(2);
		`CHK("cleared irq", 2'b00, {irq, mfOut[0]})
		// manual mode: flag only
		bus(OFS_CTRL, 1'b1, 32'h0);
		{chgFault, dsgFault} <= 2'b11;
		wt(3);
		`CHK("manual", 4'hf, {chgDrive, dsgDrive, irq, mfOut[0]})
		{chgFault, dsgFault} <= 2'b00;
		bus(OFS_STATUS, 1'b1, 32'h1);
		bus(OFS_CTRL, 1'b1, 32'h1);
		fuseReq <= 1'b1;
		wt(3);
		`CHK("fuse", 1'b1, fuseDrive)
		fuseReq <= 1'b0;
		// short reset pulse, then a full hold
		bus(OFS_CTRL, 1'b1, 32'h3);
		shutReq <= 1'b1;
		wt(4);
		`CHK("soft reset", 2'b10, {serialRst, linkSel})
		chgReq <= 1'b0;
		wt(3);
		`CHK("drives kept", 2'b11, {chgDrive, fuseDrive})
		shutReq <= 1'b0;
		wt(2 * HOLD);
		`CHK("no shutdown", 1'b0, shutdownMode)
		shutReq <= 1'b1;
		wt(2 * HOLD);
		`CHK("shutdown", 9'h100, pwrSeen)
		bus(OFS_STATE, 1'b0, 32'h0);
		`CHK("state", 32'ha0, rd)
		finish_test;
	end
endmodule
`default_nettype wire
